// >>> lcc_pkg.sv
// shared constants, modes and carriers for the logic cell row
`default_nettype none
package lcc_pkg;
    // ---------------------------------------------------------------
    // geometry
    // ---------------------------------------------------------------
    localparam int CLU_CELLS = 8;
    localparam int NUM_GLOB = 4;
    localparam int NUM_DED = 6;

    // ---------------------------------------------------------------
    // register byte offsets
    // ---------------------------------------------------------------
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_LUT = 8'h04;
    localparam logic [7:0] A_DIN0 = 8'h08;
    localparam logic [7:0] A_DIN1 = 8'h0C;
    localparam logic [7:0] A_DIN2 = 8'h10;
    localparam logic [7:0] A_DIN3 = 8'h14;
    localparam logic [7:0] A_LINES = 8'h18;
    localparam logic [7:0] A_OE = 8'h1C;
    localparam logic [7:0] A_GSEL = 8'h20;
    localparam logic [7:0] A_STEP = 8'h24;
    localparam logic [7:0] A_QOUT = 8'h28;
    localparam logic [7:0] A_COMB = 8'h2C;
    localparam logic [7:0] A_STAT = 8'h30;

    // ---------------------------------------------------------------
    // status field positions
    // ---------------------------------------------------------------
    localparam int ST_CAS = 0;
    localparam int ST_CARRY = 4;
    localparam int ST_TRI = 5;
    localparam int ST_DED = 6;
    localparam int ST_GLOB = 12;

    // ---------------------------------------------------------------
    // modes and carriers
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {M_LOGIC, M_ARITH, M_UPDN, M_CLRCNT} lcc_mode_e;
    typedef enum logic [2:0] {A_CLR, A_PRE, A_CLRPRE, A_LDCLR, A_LDPRE, A_LD} lcc_amode_e;

    // packed msb first: ctrl bit 0 is mode[0], bit 10 is link_en
    typedef struct packed {
        logic link_en;
        logic crst_en;
        logic pr_inv;
        logic clr_sel;
        lcc_amode_e amode;
        logic bypass;
        logic casc_or;
        lcc_mode_e mode;
    } lcc_ctrl_s;
    localparam int CTRL_W = 11;

    // lines bit 0 is line_one, bit 4 is the cascade-in position bit
    typedef struct packed {
        logic casc_bit;
        logic cin;
        logic chip_rst;
        logic line_two;
        logic line_one;
    } lcc_lines_s;
    localparam int LINES_W = 5;

    // ---------------------------------------------------------------
    // reset values
    // ---------------------------------------------------------------
    localparam lcc_ctrl_s CTRL_RST = lcc_ctrl_s'(11'h000);
    localparam lcc_lines_s LINES_RST = lcc_lines_s'(5'h00);
    localparam logic [15:0] LUT_RST = 16'h0000;
endpackage
`default_nettype wire

// >>> lcc_row.sv
// logic cell row: cascade and carry chains, counters, register control, apb slave
// Function
// [R1] cascade joins lookup outputs by and or or
// [R2] each chained cell adds four inputs
// [R3] long cascades link cluster to cluster plus two
// [R4] cascades never cross the row centre
// [R5] carry-out feeds next cell's carry-in
// [R6] adder register bypassed or used as accumulator
// [R7] counter: enable, clock enable, direction, load
// [R8] two lookups: next bit and fast carry
// [R9] mux sync load; async load via clear/preset
// [R10] clearable counter: sync clear from cascade-in
// [R11] sync clear ands load mux output
// [R12] emulated bus: contention low, float high
// [R13] either control line may clear asynchronously
// [R14] async load takes data when line one asserted
// [R15] clear and preset are active low
// [R16] six asynchronous clear/preset/load modes
// [R17] chip-wide reset overrides all register controls
// [R18] globals from dedicated pins or internal logic
// [R19] clear beats preset when both asserted
`default_nettype none
module lcc_row #(
    parameter int NCLU = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // dedicated control pins and global lines
    input wire logic [5:0] ded_in,
    output logic [3:0] glob_o
);
    localparam int CS = lcc_pkg::CLU_CELLS;
    localparam int N = NCLU * CS;
    localparam int HALF = NCLU / 2;

    typedef struct packed {
        logic [5:0] sy1;
        logic [5:0] sy2;
        logic rdy;
        logic err;
        logic [31:0] rdat;
        lcc_pkg::lcc_ctrl_s ctrl;
        lcc_pkg::lcc_lines_s ln;
        logic [15:0] lut;
        logic [3:0][N-1:0] din;
        logic [N-1:0] oe;
        logic [3:0] gsel;
        logic [N-1:0] qr;
        logic [3:0] glob;
        logic step;
    } lcc_state_s;

    lcc_state_s st_ff;
    lcc_state_s nxt_st;
    lcc_pkg::lcc_ctrl_s c;
    lcc_pkg::lcc_lines_s l;
    logic [N-1:0] lut_o;
    logic [N-1:0] cas;
    logic [N-1:0] cout;
    logic [N-1:0] cin_w;
    logic [N-1:0] comb;
    logic [N-1:0] clr_n;
    logic [N-1:0] pre_n;
    logic [N-1:0] qv;
    logic [N-1:0] outv;
    logic cnt_mode;
    logic lc;
    logic lo;
    logic crst;
    logic trib;
    logic acc;
    logic hit;
    logic [31:0] rd;
    logic [3:0] clu_out;

    assign c = st_ff.ctrl;
    assign l = st_ff.ln;
    assign cnt_mode = (c.mode == lcc_pkg::M_UPDN) || (c.mode == lcc_pkg::M_CLRCNT);
    // stored bit is inverted when preset is emulated by inversion
    assign qv = st_ff.qr ^ {N{c.pr_inv}};
    assign lc = c.clr_sel ? l.line_two : l.line_one; // R13
    assign lo = c.clr_sel ? l.line_one : l.line_two;
    assign crst = c.crst_en & l.chip_rst;
    assign acc = psel & penable;

    // ---------------------------------------------------------------
    // per-cell datapath
    // ---------------------------------------------------------------
    for (genvar i = 0; i < N; i++) begin : g_cell
        logic [3:0] x;
        logic cc;
        logic b;
        logic sum;
        logic cnt;
        logic ld;
        logic cm;
        logic co;
        logic ca;
        logic pa;
        assign x = {st_ff.din[3][i], st_ff.din[2][i], st_ff.din[1][i], st_ff.din[0][i]};
        assign lut_o[i] = st_ff.lut[x];
        if (i == 0) begin : g_c0
            assign cin_w[i] = l.cin;
        end else begin : g_cn
            assign cin_w[i] = cout[i-1]; // R5
        end
        if (i % CS != 0) begin : g_cas_in
            assign cc = cas[i-1];
        end else if (i / CS >= 2 && ((i / CS >= HALF) == (i / CS - 2 >= HALF))) begin : g_link
            // last cell of cluster two back, same half of the row only
            assign cc = c.link_en ? cas[i-CS-1] : ~c.casc_or; // R3 R4
        end else begin : g_new
            assign cc = ~c.casc_or; // R4
        end
        // or chains use the or identity, the de morgan form of the and chain
        assign cas[i] = c.casc_or ? (cc | lut_o[i]) : (cc & lut_o[i]); // R1 R2
        assign b = c.bypass ? st_ff.din[1][i] : qv[i]; // R6
        assign sum = st_ff.din[0][i] ^ b ^ cin_w[i];
        assign cnt = qv[i] ^ cin_w[i]; // R8
        assign ld = st_ff.din[1][i] ? st_ff.din[0][i] : cnt; // R9
        always_comb begin
            case (c.mode)
                lcc_pkg::M_ARITH: begin
                    cm = sum;
                    co = (st_ff.din[0][i] & b) | (cin_w[i] & (st_ff.din[0][i] ^ b)); // R5
                end
                lcc_pkg::M_UPDN: begin
                    cm = ld;
                    co = cin_w[i] & (l.casc_bit ? qv[i] : ~qv[i]); // R7 R8
                end
                lcc_pkg::M_CLRCNT: begin
                    cm = ld & ~l.casc_bit; // R10 R11
                    co = cin_w[i] & qv[i];
                end
                default: begin
                    cm = cas[i];
                    co = 1'b0;
                end
            endcase
        end
        assign comb[i] = cm;
        assign cout[i] = co;
        // asynchronous controls; load goes through clear/preset, not the lookup
        always_comb begin
            ca = 1'b0;
            pa = 1'b0;
            case (c.amode)
                lcc_pkg::A_CLR: begin
                    ca = lc; // R13
                end
                lcc_pkg::A_PRE: begin
                    pa = lc;
                end
                lcc_pkg::A_CLRPRE: begin
                    ca = lc;
                    pa = lo;
                end
                lcc_pkg::A_LDCLR: begin
                    ca = (l.line_one & ~x[3]) | l.line_two; // R14
                    pa = l.line_one & x[3];
                end
                lcc_pkg::A_LDPRE: begin
                    ca = l.line_one & ~x[3];
                    pa = (l.line_one & x[3]) | l.line_two;
                end
                lcc_pkg::A_LD: begin
                    ca = l.line_one & ~x[3]; // R9 R14
                    pa = l.line_one & x[3];
                end
                default: begin
                    ca = 1'b0;
                    pa = 1'b0;
                end
            endcase
        end
        // unused clear or preset sits high and never acts
        assign clr_n[i] = ~ca; // R15 R16
        assign pre_n[i] = ~pa; // R15 R16
        assign outv[i] = (c.bypass && !cnt_mode) ? comb[i] : qv[i]; // R6
    end

    for (genvar g = 0; g < NCLU; g++) begin : g_clu
        assign clu_out[g] = cas[g*CS+CS-1];
    end
    for (genvar g = NCLU; g < 4; g++) begin : g_clu_none
        assign clu_out[g] = 1'b0;
    end

    // ---------------------------------------------------------------
    // emulated internal bus
    // ---------------------------------------------------------------
    // contention resolves low, an undriven bus reads high
    always_comb begin
        if (st_ff.oe == '0) begin
            trib = 1'b1; // R12
        end else if ((st_ff.oe & (st_ff.oe - 1'b1)) != '0) begin
            trib = 1'b0; // R12
        end else begin
            trib = |(outv & st_ff.oe);
        end
    end

    // ---------------------------------------------------------------
    // register read decode
    // ---------------------------------------------------------------
    always_comb begin
        hit = (paddr[31:8] == 24'h00_0000) && (paddr[1:0] == 2'b00);
        rd = 32'h0000_0000;
        case (paddr[7:0])
            lcc_pkg::A_CTRL: rd = 32'(st_ff.ctrl);
            lcc_pkg::A_LUT: rd = 32'(st_ff.lut);
            lcc_pkg::A_DIN0: rd = 32'(st_ff.din[0]);
            lcc_pkg::A_DIN1: rd = 32'(st_ff.din[1]);
            lcc_pkg::A_DIN2: rd = 32'(st_ff.din[2]);
            lcc_pkg::A_DIN3: rd = 32'(st_ff.din[3]);
            lcc_pkg::A_LINES: rd = 32'(st_ff.ln);
            lcc_pkg::A_OE: rd = 32'(st_ff.oe);
            lcc_pkg::A_GSEL: rd = 32'(st_ff.gsel);
            lcc_pkg::A_STEP: rd = 32'h0000_0000;
            lcc_pkg::A_QOUT: rd = 32'(outv);
            lcc_pkg::A_COMB: rd = 32'(comb);
            lcc_pkg::A_STAT: begin
                rd[lcc_pkg::ST_CAS +: 4] = clu_out;
                rd[lcc_pkg::ST_CARRY] = cout[N-1];
                rd[lcc_pkg::ST_TRI] = trib;
                rd[lcc_pkg::ST_DED +: 6] = st_ff.sy2;
                rd[lcc_pkg::ST_GLOB +: 4] = st_ff.glob;
            end
            default: hit = 1'b0;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        nxt_st = st_ff;
        nxt_st.sy1 = ded_in;
        nxt_st.sy2 = st_ff.sy1;
        nxt_st.step = 1'b0;
        // answer one cycle into the access phase, data frozen meanwhile
        nxt_st.rdy = acc & ~st_ff.rdy;
        if (acc && !st_ff.rdy) begin
            nxt_st.err = ~hit;
            nxt_st.rdat = rd;
        end
        for (int k = 0; k < 4; k++) begin
            nxt_st.glob[k] = st_ff.gsel[k] ? outv[k] : st_ff.sy2[k]; // R18
        end
        if (acc && st_ff.rdy && pwrite) begin
            case (paddr[7:0])
                lcc_pkg::A_CTRL: nxt_st.ctrl = lcc_pkg::lcc_ctrl_s'(pwdata[lcc_pkg::CTRL_W-1:0]);
                lcc_pkg::A_LUT: nxt_st.lut = pwdata[15:0];
                lcc_pkg::A_DIN0: nxt_st.din[0] = pwdata[N-1:0];
                lcc_pkg::A_DIN1: nxt_st.din[1] = pwdata[N-1:0];
                lcc_pkg::A_DIN2: nxt_st.din[2] = pwdata[N-1:0];
                lcc_pkg::A_DIN3: nxt_st.din[3] = pwdata[N-1:0];
                lcc_pkg::A_LINES: nxt_st.ln = lcc_pkg::lcc_lines_s'(pwdata[lcc_pkg::LINES_W-1:0]);
                lcc_pkg::A_OE: nxt_st.oe = pwdata[N-1:0];
                lcc_pkg::A_GSEL: nxt_st.gsel = pwdata[3:0];
                lcc_pkg::A_STEP: nxt_st.step = hit;
                default: nxt_st.step = 1'b0;
            endcase
        end
        // asynchronous controls act every cycle, count/add only on a step
        if (crst) begin
            nxt_st.qr = '0; // R17
        end else begin
            for (int i = 0; i < N; i++) begin
                if (!clr_n[i]) begin
                    nxt_st.qr[i] = c.pr_inv; // R19
                end else if (!pre_n[i]) begin
                    nxt_st.qr[i] = ~c.pr_inv;
                end else if (st_ff.step) begin
                    nxt_st.qr[i] = comb[i] ^ c.pr_inv; // R7
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_ff <= '0;
            st_ff.ctrl <= lcc_pkg::CTRL_RST;
            st_ff.ln <= lcc_pkg::LINES_RST;
            st_ff.lut <= lcc_pkg::LUT_RST;
        end else begin
            st_ff <= nxt_st;
        end
    end

    assign prdata = st_ff.rdat;
    assign pready = st_ff.rdy;
    assign pslverr = st_ff.err;
    assign glob_o = st_ff.glob;

    // ---------------------------------------------------------------
    // checks
    // ---------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [N:0] add_ref;
    logic [N-1:0] acc_ref;
    assign add_ref = {1'b0, st_ff.din[0]} + {1'b0, st_ff.din[1]} + (N+1)'(l.cin);
    assign acc_ref = st_ff.din[0] + qv + N'(l.cin);

    sequence s_apb_req;
        psel && penable && !st_ff.rdy;
    endsequence
    sequence s_apb_done;
        st_ff.rdy ##1 !st_ff.rdy;
    endsequence
    sequence s_quiet;
        (&clr_n) && (&pre_n) && !crst;
    endsequence
    sequence s_sclr;
        c.mode == lcc_pkg::M_CLRCNT && l.casc_bit && st_ff.step;
    endsequence

    AST_APB_ANSWER: assert property (s_apb_req |=> s_apb_done)
        else $error("apb answer not one cycle after access");
    AST_ADDER: assert property (c.mode == lcc_pkg::M_ARITH && c.bypass // R5
        |-> {cout[N-1], comb} == add_ref) else $error("carry chain sum wrong");
    AST_ACCUM: assert property ((c.mode == lcc_pkg::M_ARITH && !c.bypass // R6
        && st_ff.step) and s_quiet |=> (st_ff.qr ^ {N{$past(c.pr_inv)}}) == $past(acc_ref))
        else $error("accumulator did not add");
    AST_CASC_AND: assert property (c.mode == lcc_pkg::M_LOGIC && !c.casc_or // R1
        |-> cas[CS-1] == &lut_o[CS-1:0]) else $error("and cascade wrong");
    AST_CASC_OR: assert property (c.casc_or |-> cas[CS-1] == |lut_o[CS-1:0]) // R2
        else $error("or cascade wrong");
    AST_SCLR: assert property (s_sclr and s_quiet |=> st_ff.qr == {N{$past(c.pr_inv)}}) // R11
        else $error("sync clear did not zero counter");
    AST_CHIP_RST: assert property (crst |=> st_ff.qr == '0) // R17
        else $error("chip reset did not override");
    AST_CLR_WINS: assert property (!clr_n[0] && !pre_n[0] && !crst // R19
        |=> st_ff.qr[0] == $past(c.pr_inv)) else $error("preset beat clear");
    AST_ALOAD: assert property (c.amode == lcc_pkg::A_LD && l.line_one && !crst // R14
        |=> (st_ff.qr[0] ^ $past(c.pr_inv)) == $past(st_ff.din[3][0]))
        else $error("async load missed data");
    AST_HOLD: assert property (!st_ff.step and s_quiet |=> st_ff.qr == $past(st_ff.qr)) // R16
        else $error("register moved without cause");
    AST_TRI: assert property ($countones(st_ff.oe) > 1 |-> !trib ##1 1'b1) // R12
        else $error("contending bus not low");
    AST_GLOB: assert property (st_ff.gsel[0] |=> glob_o[0] == $past(outv[0])) // R18
        else $error("internal global not routed");
    // less frequent register control, counter and bus paths
    AST_PRESET: assert property (c.amode == lcc_pkg::A_PRE && l.line_one // R16
        && !c.clr_sel && !crst |=> st_ff.qr[0] != $past(c.pr_inv))
        else $error("preset did not set");
    AST_LINE_TWO_CLR: assert property (c.amode == lcc_pkg::A_CLR && c.clr_sel // R13
        && l.line_two && !crst |=> st_ff.qr[0] == $past(c.pr_inv))
        else $error("line two did not clear");
    AST_UPCOUNT: assert property ((c.mode == lcc_pkg::M_UPDN && l.cin // R7
        && !st_ff.din[1][0] && st_ff.step) and s_quiet
        |=> (st_ff.qr[0] ^ $past(c.pr_inv)) != $past(qv[0]))
        else $error("counter bit did not toggle");
    AST_TRI_FLOAT: assert property (st_ff.oe == '0 |-> trib) // R12
        else $error("undriven bus not high");
endmodule
`default_nettype wire

// >>> lcc_ded_drv.sv
// dedicated control pin source standing outside the cell row
`default_nettype none
module lcc_ded_drv (
    // clock
    input wire logic pclk,
    // requested level and pins
    input wire logic [5:0] want,
    output logic [5:0] pins
);
    timeunit 1ns;
    timeprecision 1ps;
    // pins follow the requested level one edge later; the row still synchronises them
    initial pins = 6'h00;
    always @(posedge pclk) begin
        pins <= want;
    end
endmodule
`default_nettype wire

// >>> tb_top.sv
// self-checking bench for the logic cell row
`default_nettype none
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ---------------------------------------------------------------
    // signals and instances
    // ---------------------------------------------------------------
    localparam logic [31:0] ALL = 32'hFFFF_FFFF;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [5:0] ded_want = 6'h00;
    logic [5:0] ded_in;
    logic [3:0] glob_o;
    int failures = 0;
    int n_checks = 0;
    always #12.5 pclk = ~pclk;
    lcc_row #(.NCLU(4)) dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .ded_in(ded_in), .glob_o(glob_o));
    lcc_ded_drv ded (.pclk(pclk), .want(ded_want), .pins(ded_in));
    // ---------------------------------------------------------------
    // shared tasks
    // ---------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        n_checks++;
        if (s !== e) begin
            failures++;
            $display("ERROR %s expected %h seen %h", nm, e, s);
        end
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
            output logic [31:0] rd, output logic err);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {24'h00_0000, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) chk("pready", 32'h1, 32'h0);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        // idle edge so the next setup never lands in this time step
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, a, d, rd, err);
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0, rd, err);
        chk($sformatf("reg %h", a), e, rd & m);
    endtask
    task automatic step(input int k);
        repeat (k) wr(lcc_pkg::A_STEP, 32'h1);
    endtask
    // ---------------------------------------------------------------
    // scenarios
    // ---------------------------------------------------------------
    task automatic t_regs();
        logic [31:0] rd;
        logic err;
        rc(lcc_pkg::A_CTRL, ALL, 32'h0);
        rc(lcc_pkg::A_LUT, ALL, 32'h0);
        wr(lcc_pkg::A_CTRL, ALL);
        rc(lcc_pkg::A_CTRL, ALL, 32'h7FF);
        wr(lcc_pkg::A_CTRL, 32'h0);
        wr(lcc_pkg::A_QOUT, ALL);
        rc(lcc_pkg::A_QOUT, ALL, 32'h0);
        apb(1'b1, 8'h34, ALL, rd, err);
        chk("write slverr", 32'h1, {31'h0, err});
        apb(1'b0, 8'h34, 32'h0, rd, err);
        chk("read slverr", 32'h1, {31'h0, err});
        chk("read data", 32'h0, rd);
        $display("test regs done");
    endtask
    task automatic t_count();
        wr(lcc_pkg::A_CTRL, 32'h2);
        wr(lcc_pkg::A_LINES, 32'h18);
        step(3);
        rc(lcc_pkg::A_QOUT, ALL, 32'h3);
        wr(lcc_pkg::A_LINES, 32'h08);
        step(1);
        rc(lcc_pkg::A_QOUT, ALL, 32'h2);
        wr(lcc_pkg::A_LINES, 32'h10);
        step(1);
        rc(lcc_pkg::A_QOUT, ALL, 32'h2);
        wr(lcc_pkg::A_LINES, 32'h18);
        wr(lcc_pkg::A_DIN0, 32'h1234_5678);
        wr(lcc_pkg::A_DIN1, ALL);
        step(1);
        rc(lcc_pkg::A_QOUT, ALL, 32'h1234_5678);
        wr(lcc_pkg::A_DIN1, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h3);
        step(1);
        rc(lcc_pkg::A_QOUT, ALL, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h2);
        wr(lcc_pkg::A_LINES, 32'h08);
        step(1);
        rc(lcc_pkg::A_QOUT, ALL, ALL);
        wr(lcc_pkg::A_CTRL, 32'h3);
        step(1);
        rc(lcc_pkg::A_QOUT, ALL, 32'h0);
        $display("test count done");
    endtask
    task automatic t_arith();
        wr(lcc_pkg::A_LINES, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h9);
        wr(lcc_pkg::A_DIN0, 32'h7F);
        wr(lcc_pkg::A_DIN1, 32'h1);
        rc(lcc_pkg::A_COMB, ALL, 32'h80);
        rc(lcc_pkg::A_QOUT, 32'hFF, 32'h80);
        wr(lcc_pkg::A_DIN0, ALL);
        rc(lcc_pkg::A_COMB, ALL, 32'h0);
        rc(lcc_pkg::A_STAT, 32'h10, 32'h10);
        wr(lcc_pkg::A_CTRL, 32'h1);
        wr(lcc_pkg::A_DIN0, 32'h3);
        wr(lcc_pkg::A_DIN1, 32'h0);
        step(2);
        rc(lcc_pkg::A_QOUT, ALL, 32'h6);
        $display("test arith done");
    endtask
    task automatic t_async();
        wr(lcc_pkg::A_DIN3, 32'hA5A5_0F0F);
        wr(lcc_pkg::A_CTRL, 32'h50);
        wr(lcc_pkg::A_LINES, 32'h1);
        rc(lcc_pkg::A_QOUT, ALL, 32'hA5A5_0F0F);
        wr(lcc_pkg::A_GSEL, 32'hF);
        repeat (2) @(posedge pclk);
        chk("glob", 32'hF, {28'h0, glob_o});
        wr(lcc_pkg::A_LINES, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h80);
        wr(lcc_pkg::A_LINES, 32'h2);
        rc(lcc_pkg::A_QOUT, ALL, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h50);
        wr(lcc_pkg::A_LINES, 32'h3);
        rc(lcc_pkg::A_QOUT, ALL, 32'hA5A5_0F0F);
        wr(lcc_pkg::A_CTRL, 32'h250);
        wr(lcc_pkg::A_LINES, 32'h5);
        rc(lcc_pkg::A_QOUT, ALL, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h350);
        rc(lcc_pkg::A_QOUT, ALL, ALL);
        wr(lcc_pkg::A_LINES, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h20);
        wr(lcc_pkg::A_LINES, 32'h2);
        rc(lcc_pkg::A_QOUT, ALL, ALL);
        wr(lcc_pkg::A_LINES, 32'h3);
        rc(lcc_pkg::A_QOUT, ALL, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h10);
        rc(lcc_pkg::A_QOUT, ALL, ALL);
        wr(lcc_pkg::A_CTRL, 32'h30);
        rc(lcc_pkg::A_QOUT, ALL, 32'h0);
        wr(lcc_pkg::A_LINES, 32'h1);
        rc(lcc_pkg::A_QOUT, ALL, 32'hA5A5_0F0F);
        wr(lcc_pkg::A_CTRL, 32'h40);
        wr(lcc_pkg::A_LINES, 32'h2);
        rc(lcc_pkg::A_QOUT, ALL, ALL);
        wr(lcc_pkg::A_LINES, 32'h0);
        wr(lcc_pkg::A_CTRL, 32'h0);
        wr(lcc_pkg::A_GSEL, 32'h0);
        $display("test async done");
    endtask
    task automatic t_ded();
        ded_want <= 6'h2A;
        repeat (5) @(posedge pclk);
        chk("glob", 32'hA, {28'h0, glob_o});
        rc(lcc_pkg::A_STAT, 32'hFFC0, 32'hAA80);
        $display("test ded done");
    endtask
    task automatic t_tri();
        wr(lcc_pkg::A_OE, 32'h0);
        rc(lcc_pkg::A_STAT, 32'h20, 32'h20);
        // every cell output is high here, so a low bus can only come from contention
        wr(lcc_pkg::A_OE, 32'h3);
        rc(lcc_pkg::A_STAT, 32'h20, 32'h0);
        wr(lcc_pkg::A_OE, 32'h1);
        rc(lcc_pkg::A_STAT, 32'h20, 32'h20);
        wr(lcc_pkg::A_LINES, 32'h1);
        wr(lcc_pkg::A_LINES, 32'h0);
        rc(lcc_pkg::A_STAT, 32'h20, 32'h0);
        $display("test tri done");
    endtask
    task automatic t_casc();
        wr(lcc_pkg::A_LUT, 32'h8000);
        wr(lcc_pkg::A_DIN0, ALL);
        wr(lcc_pkg::A_DIN1, ALL);
        wr(lcc_pkg::A_DIN2, ALL);
        wr(lcc_pkg::A_DIN3, ALL);
        rc(lcc_pkg::A_STAT, 32'hF, 32'hF);
        wr(lcc_pkg::A_DIN0, 32'hFFFF_FFDF);
        rc(lcc_pkg::A_STAT, 32'hF, 32'hE);
        // four clusters: cluster c-2 is always across the centre, so no link may form
        wr(lcc_pkg::A_CTRL, 32'h400);
        rc(lcc_pkg::A_STAT, 32'hF, 32'hE);
        wr(lcc_pkg::A_CTRL, 32'h4);
        wr(lcc_pkg::A_DIN0, 32'h8);
        rc(lcc_pkg::A_STAT, 32'hF, 32'h1);
        $display("test casc done");
    endtask
    // ---------------------------------------------------------------
    // run control
    // ---------------------------------------------------------------
    task automatic end_sim();
        $display("checks %0d mismatches %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_regs();
        t_count();
        t_arith();
        t_async();
        t_ded();
        t_tri();
        t_casc();
        end_sim();
    end
    // the run needs well under a thousand cycles
    initial begin
        repeat (5000) @(posedge pclk);
        failures++;
        end_sim();
    end
endmodule
`default_nettype wire
